//--- dv/occ5_sva.sv
// Checker for the channel five output control block
// Assumes it is bound onto occ5_top and sees only its ports
`timescale 1ns/1ns
module occ5_sva
  import occ5_pkg::*;
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bus handshakes
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Source pulses
  input wire logic       syn_first_tick,
  input wire logic       syn_second_tick,
  input wire logic       ref_pri_tick,
  input wire logic       ref_sec_tick,
  input wire logic       ref_pri_dbl_tick,
  input wire logic       ref_sec_dbl_tick,
  // Channel
  input wire logic       ch5_tick,
  input wire logic       ch5_lvl,
  input wire logic [1:0] ch5_format,
  input wire logic [1:0] ch5_driver_setting_a,
  input wire logic [1:0] ch5_driver_setting_b,
  // Pins
  input wire logic       out_p_o,
  input wire logic       out_p_oe,
  input wire logic       out_n_o,
  input wire logic       out_n_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire any_src = syn_first_tick | syn_second_tick | ref_pri_tick | ref_sec_tick
                 | ref_pri_dbl_tick | ref_sec_dbl_tick;
  wire [1:0] f = ch5_format;
  wire [1:0] a = ch5_driver_setting_a;
  wire [1:0] b = ch5_driver_setting_b;

  property p_src; ch5_tick |-> $past(any_src); endproperty
  a_src: assert property (p_src) else $error("channel pulse without source");
  property p_lvl; $past(ch5_tick) |-> ch5_lvl != $past(ch5_lvl); endproperty
  a_lvl: assert property (p_lvl) else $error("level did not toggle");
  property p_off; $past(f) == 2'h0 |-> !out_p_oe && !out_n_oe; endproperty
  a_off: assert property (p_off) else $error("disabled output drives");
  property p_p_true;
    $past(f) == 2'h3 && $past(a) == 2'h3 |-> out_p_oe && out_p_o == $past(ch5_lvl);
  endproperty
  a_p_true: assert property (p_p_true) else $error("positive pin not true");
  property p_p_low; $past(f) == 2'h3 && $past(a) == 2'h1 |-> out_p_oe && !out_p_o; endproperty
  a_p_low: assert property (p_p_low) else $error("positive pin not low");
  property p_p_inv;
    $past(f) == 2'h3 && $past(a) == 2'h2 |-> out_p_oe && out_p_o != $past(ch5_lvl);
  endproperty
  a_p_inv: assert property (p_p_inv) else $error("positive pin not inverted");
  property p_p_tri; $past(f) == 2'h3 && $past(a) == 2'h0 |-> !out_p_oe; endproperty
  a_p_tri: assert property (p_p_tri) else $error("positive pin not tri-state");
  property p_n_low; $past(f) == 2'h3 && $past(b) == 2'h1 |-> out_n_oe && !out_n_o; endproperty
  a_n_low: assert property (p_n_low) else $error("negative pin not low");
  property p_n_inv;
    $past(f) == 2'h3 && $past(b) == 2'h2 |-> out_n_oe && out_n_o != $past(ch5_lvl);
  endproperty
  a_n_inv: assert property (p_n_inv) else $error("negative pin not inverted");
  property p_n_hcsl; $past(f) == 2'h2 && $past(b) == 2'h0 |-> !out_n_oe; endproperty
  a_n_hcsl: assert property (p_n_hcsl) else $error("negative pin not tri-state");
  property p_bhold; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bhold: assert property (p_bhold) else $error("write taken during response");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");

  c_tick: cover property (ch5_tick && f == 2'h3);
  c_read: cover property (s_axi_rvalid);
  c_off: cover property (f == 2'h0 && !out_p_oe);
endmodule : occ5_sva

//--- dv/occ5_top_bench.sv
// Testbench for the channel five output control block
// Assumes the design files and occ5_sva.sv are compiled first
`timescale 1ns/1ns
module occ5_top_bench
  import occ5_pkg::*;
;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        syn_first_tick, syn_second_tick, ref_pri_tick, ref_sec_tick;
  logic        ref_pri_dbl_tick, ref_sec_dbl_tick, ch5_tick, ch5_lvl;
  logic [1:0]  ch5_format, ch5_driver_setting_a, ch5_driver_setting_b;
  logic        out_p_o, out_p_oe, out_n_o, out_n_oe;
  logic [5:0]  tk;
  logic [7:0]  pat [6] = '{8'h3e, 8'h37, 8'h39, 8'h30, 8'h28, 8'h00};
  int          bad_count, checked;

  assign {ref_sec_dbl_tick, ref_pri_dbl_tick, ref_sec_tick, ref_pri_tick,
          syn_second_tick, syn_first_tick} = tk;

  occ5_top u_occ5_top (.*);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // A wait that runs out ends the run at once
  task automatic tmo(input int i);
    if (i >= 50)
    begin
      bad_count++;
      results();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo(i);
    chk("bresp", 32'(r), 32'(s_axi_bresp));
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    tmo(i);
    chk("rdata", d, s_axi_rdata);
    chk("rresp", 32'(r), 32'(s_axi_rresp));
    @(posedge aclk);
  endtask : rd

  // Pulses source k every other cycle n times and counts channel pulses
  task automatic run(input int k, input int n, output int c);
    c = 0;
    for (int j = 0; j < 2 * n + 6; j++)
    begin
      @(posedge aclk);
      if (ch5_tick === 1'b1) c++;
      tk <= (j < 2 * n && j % 2 == 0) ? 6'h01 << k : 6'h00;
    end
  endtask : run

  initial
  begin
    int c, e;
    aresetn = 1'b0;
    tk = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h9c, 32'h18, 2'h0);
    rd(8'ha0, 32'h02, 2'h0);
    rd(8'hfc, 32'h00, 2'h2);
    wr(8'ha8, 32'h01, 2'h2);
    $display("test registers done");
    run(0, 6, c);
    chk("div3", 2, c);
    wr(8'ha0, 32'h00, 2'h0);
    run(0, 6, c);
    chk("div1", 6, c);
    wr(8'ha0, 32'hff, 2'h0);
    run(0, 256, c);
    chk("div256", 1, c);
    wr(8'ha0, 32'h01, 2'h0);
    // Lane 0 strobe low: answered OKAY but the register keeps its value
    s_axi_wstrb <= 4'he;
    wr(8'ha0, 32'h07, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'ha0, 32'h01, 2'h0);
    $display("test divider done");
    // Even pulse counts keep the divider phase at zero between runs
    for (int d = 0; d < 2; d++)
    begin
      wr(8'ha4, 32'(d), 2'h0);
      for (int s = 0; s < 4; s++)
      begin
        wr(8'h9c, 32'h18 | (s << 6), 2'h0);
        for (int k = 0; k < 6; k++)
        begin
          run(k, 6, c);
          e = (k < 2) ? ((k == s) ? 3 : 0) : ((s > 1 && k == s + 2 * d) ? 6 : 0);
          chk("ticks", e, c);
        end
      end
    end
    wr(8'ha4, 32'h00, 2'h0);
    $display("test sources done");
    foreach (pat[i])
    begin
      wr(8'h9c, 32'(pat[i]), 2'h0);
      rd(8'h9c, 32'(pat[i]), 2'h0);
      chk("fields", 32'(pat[i][5:0]),
          32'({ch5_format, ch5_driver_setting_a, ch5_driver_setting_b}));
      run(0, 6, c);
      chk("enables", 32'({pat[i][5:4] != 2'h0 && (pat[i][5:4] != 2'h3 || pat[i][3:2] != 2'h0),
                          pat[i][5:4] != 2'h0 && (pat[i][5:4] == 2'h1 || pat[i][1:0] != 2'h0)}),
          32'({out_p_oe, out_n_oe}));
    end
    $display("test pins done");
    results();
  end
endmodule : occ5_top_bench

bind occ5_top occ5_sva u_occ5_sva (.*);

//--- hw/occ5_defines.svh
// Offsets, field positions, reset values and bus codes for the channel five control block
// Assumes inclusion by bare name from the package and design modules
`ifndef OCC5_DEFINES_SVH
`define OCC5_DEFINES_SVH

// Register indices; byte address is four times the index
`define OCC5_IDX_OUTCTL   8'h27
`define OCC5_IDX_OUTDIV   8'h28
`define OCC5_IDX_REFCFG   8'h29
`define OCC5_IDX_STATUS   8'h2a

// Output control field positions
`define OCC5_SRC_HI       7
`define OCC5_SRC_LO       6
`define OCC5_FMT_HI       5
`define OCC5_FMT_LO       4
`define OCC5_MODEA_HI     3
`define OCC5_MODEA_LO     2
`define OCC5_MODEB_HI     1
`define OCC5_MODEB_LO     0

// Reset values
`define OCC5_OUTCTL_RST   8'h18
`define OCC5_OUTDIV_RST   8'h02
`define OCC5_REFCFG_RST   8'h00

// Bus answers
`define OCC5_RESP_OKAY    2'h0
`define OCC5_RESP_SLVERR  2'h2

`endif

//--- hw/occ5_div.sv
// Output divider counting source enable pulses
// Assumes src_tick is a one-cycle pulse on aclk
`timescale 1ns/1ns
module occ5_div
  import occ5_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic [WIDTH-1:0] ratio_m1,
  input  wire logic             bypass,
  // Clock pulses
  input  wire logic             src_tick,
  output logic                  out_tick
);

  // Refused at elaboration: the counter compare is only sized for these widths
  if (WIDTH < 1 || WIDTH > 16)
  begin : g_width_bad
    $error("occ5_div: WIDTH out of range");
  end

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic             wrap;

  // Ratio is field plus one; a counter past a shrunken ratio wraps at once
  assign wrap    = (cnt_r >= ratio_m1); // [R3]
  assign cnt_nxt = (bypass || wrap) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r    <= '0;
      out_tick <= 1'b0;
    end
    else
    begin
      out_tick <= src_tick && (bypass || wrap); // [R2] [R3]
      if (src_tick)
        cnt_r <= cnt_nxt;
    end
  end

endmodule : occ5_div

//--- hw/occ5_pin.sv
// Drive and enable for one output pin of channel five
// Assumes lvl is the channel clock level on aclk
`timescale 1ns/1ns
module occ5_pin
  import occ5_pkg::*;
#(
  parameter bit NEG_PIN = 1'b0
)
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic [1:0] fmt,
  input  wire logic [1:0] mode,
  input  wire logic       lvl,
  // Pin
  output logic            pin_o,
  output logic            pin_oe
);

  logic cmos_o;
  logic cmos_oe;
  logic diff_o;
  logic diff_oe;

  // Single-ended: mode decides power and polarity per pin
  assign cmos_oe = (mode != PIN_OFF_TRI); // [R5] [R6]
  assign cmos_o  = (mode == PIN_ON_TRUE) ? lvl :
                   (mode == PIN_ON_INV)  ? ~lvl : 1'b0; // [R5] [R6]
  // Differential pair: negative pin is complement; HCSL load code 0 floats it
  assign diff_oe = !(NEG_PIN && fmt == FMT_HCSL && mode == 2'h0); // [R6]
  assign diff_o  = NEG_PIN ? ~lvl : lvl;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      case (fmt) // [R4]
        FMT_CMOS:
        begin
          pin_o  <= cmos_o;
          pin_oe <= cmos_oe;
        end
        FMT_DIFF, FMT_HCSL:
        begin
          pin_o  <= diff_o;
          pin_oe <= diff_oe;
        end
        default:
        begin
          pin_o  <= 1'b0;
          pin_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule : occ5_pin

//--- hw/occ5_pkg.sv
// Types shared by the channel five control block
// Assumes occ5_defines.svh is on the include path
package occ5_pkg;

  `include "occ5_defines.svh"

  typedef enum logic [1:0] {
    SRC_SYN_FIRST  = 2'h0,
    SRC_SYN_SECOND = 2'h1,
    SRC_REF_PRI    = 2'h2,
    SRC_REF_SEC    = 2'h3
  } occ5_src_t;

  typedef enum logic [1:0] {
    FMT_OFF  = 2'h0,
    FMT_DIFF = 2'h1,
    FMT_HCSL = 2'h2,
    FMT_CMOS = 2'h3
  } occ5_fmt_t;

  typedef enum logic [1:0] {
    PIN_OFF_TRI  = 2'h0,
    PIN_OFF_LOW  = 2'h1,
    PIN_ON_INV   = 2'h2,
    PIN_ON_TRUE  = 2'h3
  } occ5_pin_mode_t;

endpackage : occ5_pkg

//--- hw/occ5_top.sv
// Channel five output control: source select, divider, driver format, AXI4-Lite registers
// Assumes source clocks arrive as one-cycle enable pulses on aclk
//
// Overview of operation
// [R1] Source field picks synthesizer or reference
// [R2] Divider acts only on synthesizer sources
// [R3] Divide ratio is field value plus one
// [R4] Format field: off, differential, HCSL, CMOS
// [R5] First mode field sets positive pin in CMOS format
// [R6] Second mode field sets negative pin in CMOS format; in HCSL its code 0 floats it
// [R7] Doubler on delivers doubled reference pulses
`timescale 1ns/1ns
module occ5_top
  import occ5_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Source clock pulses
  input  wire logic              syn_first_tick,
  input  wire logic              syn_second_tick,
  input  wire logic              ref_pri_tick,
  input  wire logic              ref_sec_tick,
  input  wire logic              ref_pri_dbl_tick,
  input  wire logic              ref_sec_dbl_tick,
  // Channel clock
  output logic                   ch5_tick,
  output logic                   ch5_lvl,
  // Driver settings
  output logic [1:0]             ch5_format,
  output logic [1:0]             ch5_driver_setting_a,
  output logic [1:0]             ch5_driver_setting_b,
  // Pins
  output logic                   out_p_o,
  output logic                   out_p_oe,
  output logic                   out_n_o,
  output logic                   out_n_oe
);

  // Refused at elaboration: narrower buses cannot reach the status register
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_addr_w_bad
    $error("occ5_top: ADDR_W out of range");
  end

  // Byte addresses of the registers
  localparam logic [ADDR_W-1:0] A_OUTCTL = ADDR_W'({`OCC5_IDX_OUTCTL, 2'b00});
  localparam logic [ADDR_W-1:0] A_OUTDIV = ADDR_W'({`OCC5_IDX_OUTDIV, 2'b00});
  localparam logic [ADDR_W-1:0] A_REFCFG = ADDR_W'({`OCC5_IDX_REFCFG, 2'b00});
  localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'({`OCC5_IDX_STATUS, 2'b00});

  // Register state
  logic [7:0]        outctl_r;
  logic [7:0]        outdiv_r;
  logic              dbl_en_r;
  logic              lvl_r;

  // Write channel state
  logic              aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_held_r;
  logic [31:0]       w_data_r;
  logic              w_strb0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;

  // Read channel state
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // Write decode
  wire               aw_take   = s_axi_awvalid && s_axi_awready;
  wire               w_take    = s_axi_wvalid && s_axi_wready;
  wire               aw_have   = aw_held_r || aw_take;
  wire               w_have    = w_held_r || w_take;
  wire               wr_go     = aw_have && w_have && !bvalid_r;
  wire [ADDR_W-1:0]  wr_addr   = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0]        wr_data   = w_held_r ? w_data_r : s_axi_wdata;
  wire               wr_lane0  = w_held_r ? w_strb0_r : s_axi_wstrb[0];
  wire               wr_ctl    = wr_addr == A_OUTCTL;
  wire               wr_div    = wr_addr == A_OUTDIV;
  wire               wr_ref    = wr_addr == A_REFCFG;
  wire               wr_ok     = wr_ctl || wr_div || wr_ref;
  wire [1:0]         wr_resp   = wr_ok ? `OCC5_RESP_OKAY : `OCC5_RESP_SLVERR;

  // Read decode
  wire               ar_take   = s_axi_arvalid && s_axi_arready;
  wire               rd_ctl    = s_axi_araddr == A_OUTCTL;
  wire               rd_div    = s_axi_araddr == A_OUTDIV;
  wire               rd_ref    = s_axi_araddr == A_REFCFG;
  wire               rd_sts    = s_axi_araddr == A_STATUS;
  wire               rd_ok     = rd_ctl || rd_div || rd_ref || rd_sts;
  wire [1:0]         rd_resp   = rd_ok ? `OCC5_RESP_OKAY : `OCC5_RESP_SLVERR;

  // Fields
  wire [1:0]         src_sel   = outctl_r[`OCC5_SRC_HI:`OCC5_SRC_LO];
  wire               bypass    = src_sel[1]; // [R2]
  wire [7:0]         status    = {6'h00, bypass, lvl_r};
  wire [7:0]         rd_byte   = rd_ctl ? outctl_r :
                                 rd_div ? outdiv_r :
                                 rd_ref ? {7'h00, dbl_en_r} :
                                 rd_sts ? status : 8'h00;

  // One write in flight: each channel stalls once its item is held
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Address and data may come in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
    end
    else
    begin
      if (aw_take && !wr_go)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (w_take && !wr_go)
      begin
        w_held_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `OCC5_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_resp;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Registers; only byte lane 0 carries data, upper lanes are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      outctl_r <= `OCC5_OUTCTL_RST;
      outdiv_r <= `OCC5_OUTDIV_RST;
      dbl_en_r <= 1'b0;
    end
    else if (wr_go && wr_lane0)
    begin
      if (wr_ctl)
        outctl_r <= wr_data[7:0];
      if (wr_div)
        outdiv_r <= wr_data[7:0];
      if (wr_ref)
        dbl_en_r <= wr_data[0];
    end
  end

  // Read answer, one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `OCC5_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= rd_resp;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // Source routing
  logic src_tick;
  wire  pri_tick = dbl_en_r ? ref_pri_dbl_tick : ref_pri_tick; // [R7]
  wire  sec_tick = dbl_en_r ? ref_sec_dbl_tick : ref_sec_tick; // [R7]

  always_comb
  begin
    case (src_sel) // [R1]
      SRC_SYN_FIRST:  src_tick = syn_first_tick;
      SRC_SYN_SECOND: src_tick = syn_second_tick;
      SRC_REF_PRI:    src_tick = pri_tick;
      SRC_REF_SEC:    src_tick = sec_tick;
      default:        src_tick = 1'b0;
    endcase
  end

  // Divider; references pass straight through
  logic div_tick;

  occ5_div #(
    .WIDTH    (8)
  ) u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ratio_m1 (outdiv_r),
    .bypass   (bypass),
    .src_tick (src_tick),
    .out_tick (div_tick)
  );

  // Channel level toggles per divided pulse, halving the pulse rate
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lvl_r <= 1'b0;
    else if (div_tick)
      lvl_r <= ~lvl_r;
  end

  assign ch5_tick             = div_tick;
  assign ch5_lvl              = lvl_r;
  assign ch5_format           = outctl_r[`OCC5_FMT_HI:`OCC5_FMT_LO]; // [R4]
  assign ch5_driver_setting_a = outctl_r[`OCC5_MODEA_HI:`OCC5_MODEA_LO]; // [R5]
  assign ch5_driver_setting_b = outctl_r[`OCC5_MODEB_HI:`OCC5_MODEB_LO]; // [R6]

  // Pins follow the level one cycle later
  occ5_pin #(
    .NEG_PIN (1'b0)
  ) u_pin_p (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fmt     (ch5_format),
    .mode    (ch5_driver_setting_a),
    .lvl     (lvl_r),
    .pin_o   (out_p_o),
    .pin_oe  (out_p_oe)
  );

  occ5_pin #(
    .NEG_PIN (1'b1)
  ) u_pin_n (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fmt     (ch5_format),
    .mode    (ch5_driver_setting_b),
    .lvl     (lvl_r),
    .pin_o   (out_n_o),
    .pin_oe  (out_n_oe)
  );

endmodule : occ5_top
